// File: pkg/rom_window_pkg.sv
// package for the program memory window and option bytes block
// assumes an 8-bit internal data bus and a single core clock
package rom_window_pkg;

  localparam logic [7:0]  BLOCK_SELECT_ADDR    = 8'hC9;
  localparam logic [7:0]  WINDOW_BASE_ADDR     = 8'h40;
  localparam logic [7:0]  WINDOW_LAST_ADDR     = 8'h7F;
  localparam int          BLOCK_FIELD_LSB      = 0;
  localparam int          BLOCK_FIELD_W        = 6;
  localparam int          WINDOW_OFFSET_W      = 6;
  localparam int          PROG_ADDR_W          = 12;
  localparam logic [15:0] OPTION_DELIVERED     = 16'h0000;
  localparam logic [15:0] OPTION_RESERVED_MASK = 16'hFC30;
  localparam int          OPT_EXTERNAL_STOP    = 9;
  localparam int          OPT_LOW_VOLTAGE_DET  = 8;
  localparam int          OPT_READ_PROTECT     = 7;
  localparam int          OPT_OSC_RC           = 6;
  localparam int          OPT_NMI_PULLUP       = 3;
  localparam int          OPT_TIMER_PULLUP     = 2;
  localparam int          OPT_WDG_ALWAYS_ON    = 1;
  localparam int          OPT_OSC_SAFEGUARD    = 0;

  // decoded hardware configuration
  typedef struct packed {
    logic external_stop_control;
    logic low_voltage_detector_enable;
    logic read_protect;
    logic osc_rc_select;
    logic nmi_pin_pullup;
    logic timer_pin_pullup;
    logic watchdog_always_on;
    logic osc_safeguard_enable;
  } option_cfg_t;

  // programming tool access to option bytes
  typedef struct packed {
    logic        write;
    logic        read;
    logic        high_byte;
    logic [7:0]  wdata;
  } option_req_t;

endpackage : rom_window_pkg

// File: rtl/option_byte_cell.sv
// one-time-programmable option byte cell
// assumes writes come only from the programming port logic
`timescale 1ns/100ps
module option_byte_cell
  import rom_window_pkg::*;
#(
  parameter logic [7:0] DELIVERED = 8'h00
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // programming
  input  wire logic       program_i,
  input  wire logic [7:0] wdata_i,
  // content
  output logic [7:0]      value_o,
  output logic            burnt_o
);

  // reset models power-up of fuse sense: value returns to delivered, burnt flag clears
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      value_o <= DELIVERED;
    end else if (program_i && !burnt_o) begin
      value_o <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      burnt_o <= 1'b0;
    end else if (program_i) begin
      burnt_o <= 1'b1;
    end
  end

endmodule : option_byte_cell

// File: rtl/program_memory_window_options.sv
// data-space window onto program memory plus option bytes
// assumes the core presents one data-space access per cycle and
// program memory returns read data one cycle after the address
`timescale 1ns/100ps

// How it works
// - block-select register decoded at data address C9h
// - window reads 40h..7Fh return bytes from selected block
// - block-select not reset; software writes it first
// - bits 5:0 select block; bits 7:6 reserved, written zero
// - option bytes unmapped; reachable only in programming mode
// - each option byte programs once, later writes ignored until next reset
// - user-programmable option bytes deliver as 00h
// - factory-coded options fixed, no read-back
// - bit 9 allows stop with watchdog if NMI high
// - bit 8 enables low-voltage detector
// - bit 7 blocks external program memory read-out
// - bit 6 selects RC oscillator, else crystal
// - bit 3 enables NMI pin pull-up
// - bit 2 enables timer pin pull-up
// - bit 1 makes watchdog always on
// - bit 0 enables oscillator safeguard
// - block 0 maps 0000h..003Fh, next blocks consecutive
module program_memory_window_options
  import rom_window_pkg::*;
#(
  parameter bit          FACTORY_CODED  = 1'b0,
  parameter logic [15:0] FACTORY_OPTION = 16'h0000
) (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   sys_rst_i,
  // core data-space bus
  input  wire logic [7:0]             data_addr_i,
  input  wire logic                   data_wr_i,
  input  wire logic                   data_rd_i,
  input  wire logic [7:0]             data_wdata_i,
  output logic                        window_hit_o,
  output logic [7:0]                  window_rdata_o,
  // program memory read port
  output logic [PROG_ADDR_W-1:0]      prog_addr_o,
  output logic                        prog_rd_o,
  input  wire logic [7:0]             prog_rdata_i,
  // programming mode pin and tool port
  input  wire logic                   prog_mode_pin_i,
  input  wire option_req_t            option_req_i,
  output logic [7:0]                  option_rdata_o,
  output logic                        option_ack_o,
  // decoded configuration
  input  wire logic                   nmi_pin_i,
  input  wire logic                   watchdog_active_i,
  output option_cfg_t                 cfg_o,
  output logic                        stop_allowed_o
);

  // elaboration checks: constants the datapath cannot serve are refused
  localparam int OPT_POSITION [8] = '{OPT_EXTERNAL_STOP, OPT_LOW_VOLTAGE_DET, OPT_READ_PROTECT, OPT_OSC_RC,
                                      OPT_NMI_PULLUP, OPT_TIMER_PULLUP, OPT_WDG_ALWAYS_ON, OPT_OSC_SAFEGUARD};

  if (PROG_ADDR_W != BLOCK_FIELD_W + WINDOW_OFFSET_W) begin : g_bad_addr_w
    $error("program address width must equal block plus offset width");
  end

  if (BLOCK_FIELD_LSB + BLOCK_FIELD_W > 8) begin : g_bad_block_field
    $error("block field must fit in the data byte");
  end

  // offset bits of the data address go straight through, so the window must be one aligned block
  if (WINDOW_LAST_ADDR - WINDOW_BASE_ADDR != 8'((1 << WINDOW_OFFSET_W) - 1)) begin : g_bad_window_span
    $error("window span must equal one program memory block");
  end

  if ((WINDOW_BASE_ADDR & 8'((1 << WINDOW_OFFSET_W) - 1)) != 8'h00) begin : g_bad_window_align
    $error("window base must be aligned to one block");
  end

  if ((FACTORY_OPTION & OPTION_RESERVED_MASK) != 16'h0000) begin : g_bad_factory_option
    $error("factory options must leave reserved bits clear");
  end

  if ((OPTION_DELIVERED & OPTION_RESERVED_MASK) != 16'h0000) begin : g_bad_delivered
    $error("delivered option value must leave reserved bits clear");
  end

  // every decoded option bit must sit inside the word and off the reserved bits
  for (genvar g = 0; g < 8; g++) begin : g_opt_position
    if (OPT_POSITION[g] < 0 || OPT_POSITION[g] > 15) begin : g_out_of_word
      $error("option bit position outside the option word");
    end else if (OPTION_RESERVED_MASK[OPT_POSITION[g]]) begin : g_on_reserved
      $error("option bit position falls on a reserved bit");
    end
  end

  logic [BLOCK_FIELD_W-1:0] rom_window_block_select;
  logic                     block_written;
  logic                     rd_pending;
  logic                     mode_meta;
  logic                     mode_sync;
  logic                     nmi_meta;
  logic                     nmi_sync;
  logic                     in_window;
  logic [15:0]              option_word;
  logic [15:0]              option_used;
  logic                     block_wr_hit;
  logic                     window_rd_hit;
  logic                     opt_enabled;
  logic                     opt_write;
  logic                     opt_read;
  logic [1:0]               opt_program;
  logic [7:0]               opt_readback;
  logic                     nmi_allows_stop;

  // register address decode, shared by the register and its written flag
  assign block_wr_hit = data_wr_i && (data_addr_i == BLOCK_SELECT_ADDR);

  // no reset value: the register holds whatever was last written
  // only bits 5:0 stored, reserved bits dropped
  always_ff @(posedge ref_clk_i) begin
    if (block_wr_hit) begin
      rom_window_block_select <= data_wdata_i[BLOCK_FIELD_LSB +: BLOCK_FIELD_W];
    end
  end

  // tracks first write; reads before it return undefined-as-zero
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      block_written <= 1'b0;
    end else if (block_wr_hit) begin
      block_written <= 1'b1;
    end
  end

  assign in_window     = (data_addr_i >= WINDOW_BASE_ADDR) && (data_addr_i <= WINDOW_LAST_ADDR);
  assign window_rd_hit = data_rd_i && in_window;

  // block bits above address low bits
  assign prog_addr_o = {rom_window_block_select, data_addr_i[WINDOW_OFFSET_W-1:0]};
  assign prog_rd_o   = window_rd_hit;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= window_rd_hit;
    end
  end

  // returned data registered at the end of the cycle in which it returns, one cycle after the read
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      window_rdata_o <= 8'h00;
    end else if (rd_pending) begin
      window_rdata_o <= block_written ? prog_rdata_i : 8'h00;
    end
  end

  assign window_hit_o = rd_pending;

  // pin synchronisers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      nmi_meta  <= 1'b0;
      nmi_sync  <= 1'b0;
    end else begin
      mode_meta <= prog_mode_pin_i;
      mode_sync <= mode_meta;
      nmi_meta  <= nmi_pin_i;
      nmi_sync  <= nmi_meta;
    end
  end

  // tool access only while programming mode is held
  // factory parts have no programmable cells, so tool writes and reads are blocked there; requests are still acked
  assign opt_enabled = mode_sync && !FACTORY_CODED;
  assign opt_write   = opt_enabled && option_req_i.write;
  assign opt_read    = opt_enabled && option_req_i.read;

  // one-time cells delivered as zero, one per option byte
  for (genvar b = 0; b < 2; b++) begin : g_option_byte
    assign opt_program[b] = opt_write && (option_req_i.high_byte == 1'(b));

    option_byte_cell #(
      .DELIVERED (OPTION_DELIVERED[8*b +: 8])
    ) u_option_byte (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .program_i (opt_program[b]),
      .wdata_i   (option_req_i.wdata),
      .value_o   (option_word[8*b +: 8]),
      .burnt_o   ()
    );
  end

  // reserved option bits never reach the configuration
  assign option_used = (FACTORY_CODED ? FACTORY_OPTION : option_word) & ~OPTION_RESERVED_MASK;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      option_ack_o <= 1'b0;
    end else begin
      option_ack_o <= mode_sync && (option_req_i.write || option_req_i.read);
    end
  end

  assign opt_readback = option_req_i.high_byte ? option_word[15:8] : option_word[7:0];

  // read-back only in programming mode, never on factory parts
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      option_rdata_o <= 8'h00;
    end else if (opt_read) begin
      option_rdata_o <= opt_readback;
    end else begin
      option_rdata_o <= 8'h00;
    end
  end

  assign cfg_o.external_stop_control       = option_used[OPT_EXTERNAL_STOP];
  assign cfg_o.low_voltage_detector_enable = option_used[OPT_LOW_VOLTAGE_DET];
  assign cfg_o.read_protect                = option_used[OPT_READ_PROTECT];
  assign cfg_o.osc_rc_select               = option_used[OPT_OSC_RC];
  assign cfg_o.nmi_pin_pullup              = option_used[OPT_NMI_PULLUP];
  assign cfg_o.timer_pin_pullup            = option_used[OPT_TIMER_PULLUP];
  assign cfg_o.watchdog_always_on          = option_used[OPT_WDG_ALWAYS_ON];
  assign cfg_o.osc_safeguard_enable        = option_used[OPT_OSC_SAFEGUARD];

  // stop gating under watchdog
  // the pin is synchronised, so a change reaches the gate two cycles late
  assign nmi_allows_stop = option_used[OPT_EXTERNAL_STOP] && nmi_sync;
  assign stop_allowed_o  = !watchdog_active_i || nmi_allows_stop;

endmodule : program_memory_window_options

// File: testbench/pmw_checker_sva.sv
// assertions on the window and option block ports
// assumes one core clock and an async active-high reset
`timescale 1ns/100ps
module pmw_checker
  import rom_window_pkg::*;
(
  // clock and reset
  input wire logic                   ref_clk_i,
  input wire logic                   sys_rst_i,
  // core bus
  input wire logic [7:0]             data_addr_i,
  input wire logic                   data_wr_i,
  input wire logic                   data_rd_i,
  input wire logic [7:0]             data_wdata_i,
  input wire logic                   window_hit_o,
  input wire logic [PROG_ADDR_W-1:0] prog_addr_o,
  input wire logic                   prog_rd_o,
  // options
  input wire logic                   prog_mode_pin_i,
  input wire option_req_t            option_req_i,
  input wire logic                   option_ack_o,
  input wire logic                   watchdog_active_i,
  input wire option_cfg_t            cfg_o,
  input wire logic                   stop_allowed_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic in_win;
  logic opt_req;
  assign in_win = data_addr_i >= WINDOW_BASE_ADDR && data_addr_i <= WINDOW_LAST_ADDR;
  assign opt_req = option_req_i.write || option_req_i.read;
  sequence blk_wr;
    data_wr_i && data_addr_i == BLOCK_SELECT_ADDR;
  endsequence
  sequence win_rd;
    data_rd_i && in_win;
  endsequence
  chk_win_answer: assert property (win_rd |=> window_hit_o)
    else $error("window read not answered");
  chk_no_stray: assert property (!(data_rd_i && in_win) |=> !window_hit_o)
    else $error("hit without window read");
  chk_prog_strobe: assert property (prog_rd_o == (data_rd_i && in_win))
    else $error("program read strobe wrong");
  chk_offset_bits: assert property (prog_rd_o |-> prog_addr_o[5:0] == data_addr_i[5:0])
    else $error("window offset not passed");
  chk_block_bits: assert property (blk_wr ##1 win_rd |-> prog_addr_o[11:6] == $past(data_wdata_i[5:0]))
    else $error("block bits not applied");
  chk_opt_mode: assert property (!prog_mode_pin_i [*3] ##0 opt_req |=> !option_ack_o)
    else $error("option access outside programming mode");
  chk_ack_cause: assert property (option_ack_o |-> $past(opt_req))
    else $error("ack without request");
  chk_cfg_once: assert property ($changed(cfg_o) |-> option_ack_o && $past(option_req_i.write))
    else $error("options changed without write");
  chk_stop_free: assert property (!watchdog_active_i |-> stop_allowed_o)
    else $error("stop refused without watchdog");
  chk_stop_blocked: assert property (watchdog_active_i && !cfg_o.external_stop_control |-> !stop_allowed_o)
    else $error("stop allowed with watchdog");
endmodule : pmw_checker

bind program_memory_window_options pmw_checker i_chk (.ref_clk_i, .sys_rst_i, .data_addr_i, .data_wr_i,
  .data_rd_i, .data_wdata_i, .window_hit_o, .prog_addr_o, .prog_rd_o, .prog_mode_pin_i, .option_req_i,
  .option_ack_o, .watchdog_active_i, .cfg_o, .stop_allowed_o);

// File: testbench/prog_mem_model.sv
// program memory read port model
// assumes reads are addressed one cycle before data is taken
`timescale 1ns/100ps
module prog_mem_model
  import rom_window_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic [PROG_ADDR_W-1:0] prog_addr_i,
  input  wire logic                   prog_rd_i,
  output logic [7:0]                  prog_rdata_o
);
  // data valid next cycle
  // idle cycles toggle, so stale data never looks valid
  initial prog_rdata_o = 8'h5A;
  always @(posedge ref_clk_i) begin
    if (prog_rd_i)
      prog_rdata_o <= prog_addr_i[7:0] ^ {prog_addr_i[11:8], 4'h3};
    else
      prog_rdata_o <= ~prog_rdata_o;
  end
endmodule : prog_mem_model

// File: testbench/program_memory_window_options_bench.sv
// bench for the window and option block
// assumes the program memory model answers the cycle after a read
`timescale 1ns/100ps
module program_memory_window_options_bench;
  import rom_window_pkg::*;
  logic ref_clk_i, sys_rst_i, wr, rd, pin, nmi, wdg, hit, ack, stop, prd;
  logic [7:0] addr, wdata, rdata, ordata, prdata;
  logic [11:0] paddr;
  option_req_t req;
  option_cfg_t cfg;
  int fails, cmp_count;
  logic [7:0] blk_image;
  logic [5:0] blks [3] = '{6'h00, 6'h01, 6'h3F};
  logic [7:0] outs [3] = '{8'h3F, 8'h80, 8'h00};

  program_memory_window_options i_dut (.ref_clk_i, .sys_rst_i, .data_addr_i(addr), .data_wr_i(wr),
    .data_rd_i(rd), .data_wdata_i(wdata), .window_hit_o(hit), .window_rdata_o(rdata),
    .prog_addr_o(paddr), .prog_rd_o(prd), .prog_rdata_i(prdata), .prog_mode_pin_i(pin),
    .option_req_i(req), .option_rdata_o(ordata), .option_ack_o(ack), .nmi_pin_i(nmi),
    .watchdog_active_i(wdg), .cfg_o(cfg), .stop_allowed_o(stop));
  prog_mem_model i_mem (.ref_clk_i, .prog_addr_i(paddr), .prog_rd_i(prd), .prog_rdata_o(prdata));

  function automatic logic [7:0] pm(input logic [5:0] b, input logic [5:0] o);
    return {b[1:0], o} ^ {b[5:2], 4'h3};
  endfunction : pm
  task automatic close_out;
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    // image updated before the register itself
    if (a == BLOCK_SELECT_ADDR) blk_image = d;
    addr = a;
    wdata = d;
    wr = 1'h1;
    tick(1);
    wr = 1'h0;
  endtask : wr_reg
  task automatic rd_win(input logic [7:0] a, input logic [7:0] exp);
    int n;
    addr = a;
    rd = 1'h1;
    tick(1);
    rd = 1'h0;
    for (n = 0; n < 4 && hit !== 1'h1; n++) tick(1);
    if (hit !== 1'h1) begin
      fails++;
      close_out();
    end else begin
      tick(1);
      check(rdata, exp);
    end
  endtask : rd_win
  task automatic opt(input logic w, hi, input logic [7:0] d, input logic a_exp, input logic [7:0] r_exp);
    req = '{write: w, read: !w, high_byte: hi, wdata: d};
    tick(1);
    check(ack, a_exp);
    if (!w) check(ordata, r_exp);
    req = '0;
    tick(1);
  endtask : opt

  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    {sys_rst_i, wr, rd, pin, nmi, wdg, addr, wdata, req} = '0;
    sys_rst_i = 1'h1;
    tick(20);
    sys_rst_i = 1'h0;
    check(hit, 1'h0);
    check(rdata, 8'h00);
    check(cfg, OPTION_DELIVERED[7:0]);
    {wdg, nmi} = 2'h3;
    tick(3);
    check(stop, 1'h0);
    $display("reset test done");
    // block selected before any window read, reserved bits clear
    foreach (blks[i]) begin
      wr_reg(BLOCK_SELECT_ADDR, {2'h0, blks[i]});
      rd_win(8'h40, pm(blks[i], 6'h00));
      rd_win(8'h7F, pm(blks[i], 6'h3F));
    end
    $display("window test done");
    // reads at 3Fh, 80h and 00h, outside the window, get no hit
    foreach (outs[i]) begin
      addr = outs[i];
      rd = 1'h1;
      tick(1);
      rd = 1'h0;
      check(hit, 1'h0);
      tick(1);
    end
    wr_reg(8'hC8, 8'h11);
    rd_win(8'h40, pm(blk_image[5:0], 6'h00));
    $display("decode test done");
    opt(1'h1, 1'h1, 8'h03, 1'h0, 8'h00);
    opt(1'h0, 1'h1, 8'h00, 1'h0, 8'h00);
    check(cfg, 8'h00);
    // programming voltage on the test pin
    pin = 1'h1;
    tick(3);
    opt(1'h1, 1'h1, 8'h03, 1'h1, 8'h00);
    check(cfg, 8'hC0);
    tick(2);
    check(stop, 1'h1);
    opt(1'h1, 1'h0, 8'h8A, 1'h1, 8'h00);
    check(cfg, 8'hEA);
    opt(1'h1, 1'h0, 8'h45, 1'h1, 8'h00);
    check(cfg, 8'hEA);
    opt(1'h0, 1'h0, 8'h00, 1'h1, 8'h8A);
    opt(1'h0, 1'h1, 8'h00, 1'h1, 8'h03);
    nmi = 1'h0;
    tick(3);
    check(stop, 1'h0);
    wdg = 1'h0;
    tick(1);
    check(stop, 1'h1);
    $display("option test done");
    // power-up model: cells return to the delivered state
    sys_rst_i = 1'h1;
    tick(2);
    sys_rst_i = 1'h0;
    check(cfg, 8'h00);
    check(ack, 1'h0);
    tick(3);
    opt(1'h0, 1'h1, 8'h00, 1'h1, 8'h00);
    opt(1'h1, 1'h0, 8'h45, 1'h1, 8'h00);
    check(cfg, 8'h15);
    $display("power-up test done");
    close_out();
  end
endmodule : program_memory_window_options_bench
